// ===== core/ret_cfg_pkg.sv
package ret_cfg_pkg;
  typedef logic [11:0] instr_t;
  typedef logic [7:0]  data_t;
  typedef logic [9:0]  pc_t;
  typedef enum logic [1:0] {
    ST_EXEC  = 2'h0,
    ST_FLUSH = 2'h1
  } exec_state_t;
endpackage

// ===== core/ret_cfg_regs.svh
`ifndef RET_CFG_REGS_SVH
`define RET_CFG_REGS_SVH
// Instruction encodings
`define OPC_IDLE        12'h000
`define OPC_CFG_LOAD    12'h002
`define OPC_RETLIT_MASK 12'hF00
`define OPC_RETLIT_VAL  12'h800
`define LIT_MSB         7
// Reset values and program counter step
`define W_RST           8'h00
`define CFG_RST         8'hFF
`define PC_RST          10'h3FF
`define PC_STEP         10'h001
`endif

// ===== core/return_config_nop_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "ret_cfg_regs.svh"
module return_config_nop_decode (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  // Instruction stream
  input  wire ret_cfg_pkg::instr_t  instr_i,
  input  wire ret_cfg_pkg::pc_t     stack_top_entry_i,
  // Core state
  output logic                      stack_pop_o,
  output ret_cfg_pkg::data_t        work_reg_o,
  output ret_cfg_pkg::data_t        cfg_reg_o,
  output ret_cfg_pkg::pc_t          pc_o,
  output logic                      flush_o
);
  import ret_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic is_retlit(input instr_t op);
    return (op & `OPC_RETLIT_MASK) == `OPC_RETLIT_VAL;
  endfunction

  function automatic logic is_cfg_load(input instr_t op);
    return op == `OPC_CFG_LOAD;
  endfunction

  function automatic logic is_idle(input instr_t op);
    return op == `OPC_IDLE;
  endfunction

  exec_state_t state_ff;
  exec_state_t nxt_state;
  logic        pop_ff;
  logic        nxt_pop;
  logic        flush_ff;
  logic        nxt_flush;
  data_t       work_ff;
  data_t       nxt_work;
  data_t       cfg_ff;
  data_t       nxt_cfg;
  pc_t         pc_ff;
  pc_t         nxt_pc;
  logic        take_retlit;
  logic        take_cfg;

  ////////////////////////////////////////////////////////////////////
  // Instruction acceptance, ignored in the flush cycle
  always_comb begin
    take_retlit = (state_ff == ST_EXEC) && is_retlit(instr_i);
    take_cfg    = (state_ff == ST_EXEC) && is_cfg_load(instr_i);
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencing
  always_comb begin
    nxt_state = ST_EXEC;
    nxt_pop   = 1'b0;
    nxt_flush = 1'b0;
    case (state_ff)
      ST_EXEC: begin
        if (take_retlit) begin
          nxt_state = ST_FLUSH;
          nxt_pop   = 1'b1;
          nxt_flush = 1'b1;
        end
      end
      ST_FLUSH: begin
        nxt_state = ST_EXEC;
      end
      default: begin
        nxt_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_EXEC;
      pop_ff   <= 1'b0;
      flush_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pop_ff   <= nxt_pop;
      flush_ff <= nxt_flush;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Working and configuration registers
  always_comb begin
    nxt_work = work_ff;
    nxt_cfg  = cfg_ff;
    if (take_cfg) begin
      nxt_cfg = work_ff;
    end
    if (take_retlit) begin
      nxt_work = instr_i[`LIT_MSB:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      work_ff <= `W_RST;
      cfg_ff  <= `CFG_RST;
    end else begin
      work_ff <= nxt_work;
      cfg_ff  <= nxt_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program counter
  always_comb begin
    case (state_ff)
      ST_EXEC: begin
        if (take_retlit) begin
          nxt_pc = stack_top_entry_i;
        end else begin
          nxt_pc = pc_ff + `PC_STEP;
        end
      end
      ST_FLUSH: begin
        nxt_pc = pc_ff;
      end
      default: begin
        nxt_pc = pc_ff;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_ff <= `PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign work_reg_o  = work_ff;
  assign cfg_reg_o   = cfg_ff;
  assign pc_o        = pc_ff;
  assign stack_pop_o = pop_ff;
  assign flush_o     = flush_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_cfg_load_copy: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && instr_i == `OPC_CFG_LOAD
    |=> cfg_ff == $past(work_ff))
    else $error("config load did not copy working register");

  a_retlit_literal: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && is_retlit(instr_i)
    |=> work_ff == $past(instr_i[`LIT_MSB:0]))
    else $error("literal return wrong working value");

  a_retlit_pc: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && is_retlit(instr_i)
    |=> pc_ff == $past(stack_top_entry_i) ##1 $stable(pc_ff))
    else $error("literal return wrong program counter");

  a_retlit_pop: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && is_retlit(instr_i)
    |=> stack_pop_o ##1 !stack_pop_o)
    else $error("stack pop not a single pulse");

  a_retlit_two_cyc: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && is_retlit(instr_i)
    |=> flush_o ##1 !flush_o)
    else $error("literal return not two cycles");

  a_flush_holds: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    flush_o
    |=> $stable(pc_ff) && $stable(work_ff) && $stable(cfg_ff))
    else $error("flush cycle changed state");

  a_idle_no_change: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && instr_i == `OPC_IDLE
    |=> $stable(work_ff) && $stable(cfg_ff) && !stack_pop_o)
    else $error("idle instruction changed state");

  a_idle_pc_step: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && instr_i == `OPC_IDLE
    |=> pc_ff == $past(pc_ff) + `PC_STEP)
    else $error("idle instruction did not advance pc");

  c_cfg_load: cover property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && instr_i == `OPC_CFG_LOAD);

  c_retlit: cover property (
    @(posedge clk_i) disable iff (!arst_n_i)
    flush_o);

  c_idle: cover property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_EXEC && is_idle(instr_i));

  c_cfg_after_ret: cover property (
    @(posedge clk_i) disable iff (!arst_n_i)
    flush_o ##2 (state_ff == ST_EXEC && is_cfg_load(instr_i)));

endmodule
`default_nettype wire

// ===== dv/test_return_config_nop_decode.sv
`timescale 1ns/1ns
`default_nettype none
module test_return_config_nop_decode;
  import ret_cfg_pkg::*;
  logic   clk_i, arst_n_i, stack_pop_o, flush_o;
  instr_t instr_i;
  pc_t    stack_top_entry_i, pc_o;
  data_t  work_reg_o, cfg_reg_o;
  int     miscompares = 0, checks = 0, cyc = 0;
  return_config_nop_decode dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_i(instr_i),
    .stack_top_entry_i(stack_top_entry_i), .stack_pop_o(stack_pop_o),
    .work_reg_o(work_reg_o), .cfg_reg_o(cfg_reg_o), .pc_o(pc_o), .flush_o(flush_o));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task go(input instr_t i);
    @(posedge clk_i);
    instr_i <= i;
    @(posedge clk_i);
    instr_i <= 12'h000;
    @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  // Literal return, then the idle second cycle
  task t_ret(input data_t k, input pc_t t);
    @(posedge clk_i);
    stack_top_entry_i <= t;
    go({4'h8, k});
    chk("work", {2'h0, work_reg_o}, {2'h0, k});
    chk("pc", pc_o, t);
    chk("pop", {9'h000, stack_pop_o}, 10'h001);
    chk("flush", {9'h000, flush_o}, 10'h001);
    @(negedge clk_i);
    chk("flush", {9'h000, flush_o}, 10'h000);
    chk("pop", {9'h000, stack_pop_o}, 10'h000);
    chk("pc", pc_o, t);
  endtask
  // Config load then idle word
  task t_cfg(input pc_t t, input data_t w);
    go(12'h002);
    chk("cfg", {2'h0, cfg_reg_o}, {2'h0, w});
    chk("pc", pc_o, t + 10'h002);
    go(12'h000);
    chk("cfg", {2'h0, cfg_reg_o}, {2'h0, w});
    chk("work", {2'h0, work_reg_o}, {2'h0, w});
    chk("pc", pc_o, t + 10'h004);
    chk("pop", {9'h000, stack_pop_o}, 10'h000);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 200) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    arst_n_i = 1'b0;
    instr_i = 12'h000;
    stack_top_entry_i = 10'h000;
    repeat (5) @(posedge clk_i);
    chk("cfg", {2'h0, cfg_reg_o}, 10'h0FF);
    chk("pc", pc_o, 10'h3FF);
    arst_n_i <= 1'b1;
    t_ret(8'h3C, 10'h123);
    t_cfg(10'h123, 8'h3C);
    t_ret(8'hFF, 10'h3FF);
    t_ret(8'h00, 10'h000);
    t_cfg(10'h000, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
